/* emmt_consts.vh */
// constants for the eight bit multimode timer
`ifndef EMMT_CONSTS_VH
`define EMMT_CONSTS_VH
// ==========================================
// register byte offsets
`define EMMT_OFS_CMP 12'h019
`define EMMT_OFS_CTRL 12'h015
`define EMMT_OFS_STAT 12'h020
// ==========================================
// control register fields
`define EMMT_MODE_LSB 0
`define EMMT_MODE_MSB 1
`define EMMT_SRC_LSB 2
`define EMMT_SRC_MSB 4
`define EMMT_START_BIT 5
// ==========================================
// reset values
`define EMMT_CMP_RST 8'hff
`define EMMT_CTRL_RST 6'h00
// ==========================================
// mode and source encodings
`define EMMT_MODE_TIMER 2'b00
`define EMMT_MODE_RSVD 2'b01
`define EMMT_MODE_DIV 2'b10
`define EMMT_MODE_PWM 2'b11
`define EMMT_SRC_EVENT 3'b111
`define EMMT_SRC_NONE 3'b110
// ==========================================
// event pin minimum level time in cycles
`define EMMT_EVT_MIN_CYC 2
`endif

/* emmt_edge.v */
// edge detector for the external event input
`timescale 1ns/10ps
module emmt_edge (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // pin and edges
    input wire pin_in,
    output wire rise,
    output wire fall
);
    reg last_r;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_r <= 1'b0;
        end else begin
            last_r <= pin_in;
        end
    end

    assign rise = pin_in & ~last_r;
    assign fall = ~pin_in & last_r;
endmodule

/* emmt_event_src.sv */
// event pulse source driving the timer event pin
`timescale 1ns/10ps
module emmt_event_src (
    // clock
    input wire pclk,
    // event pin
    output reg event_input_pin
);
    initial event_input_pin = 1'b0;
    task pulses(input integer n);
        repeat (n) begin
            repeat (3) @(posedge pclk) event_input_pin <= 1'b1;
            repeat (3) @(posedge pclk) event_input_pin <= 1'b0;
        end
    endtask
endmodule

/* emmt_timer.v */
// eight bit multimode timer with apb register slave
`timescale 1ns/10ps
`include "emmt_consts.vh"

module emmt_timer (
    // apb clock and reset
    input wire pclk,
    input wire presetn,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire pready,
    output wire pslverr,
    // prescaler ticks, one per source selection 000..110
    input wire [6:0] src_tick,
    // power and pins
    input wire stop_mode_entry,
    input wire event_input_pin,
    output wire divider_output_pin,
    output wire pwm_output_pin_n,
    output wire timer_interrupt_request
);
    // ==========================================
    // registers
    reg [7:0] compare_value_register;
    reg run_start_bit;
    reg [2:0] count_source_select;
    reg [1:0] operating_mode_select;
    reg [7:0] count_r;
    reg [7:0] pwm_cmp_r;
    reg div_r;
    reg pwm_r;
    reg irq_r;
    reg evt_wait_r;
    reg evt_hit_r;
    reg [31:0] rdata_r;

    wire evt_rise;
    wire evt_fall;
    wire wr_en;
    wire rd_en;
    wire addr_ok;
    wire ctrl_wr;
    wire start_rise;
    wire src_is_event;
    wire tick;
    wire match;
    wire [7:0] count_inc;

    // ==========================================
    // event pin edges
    emmt_edge u_edge (
        .pclk(pclk),
        .presetn(presetn),
        .pin_in(event_input_pin),
        .rise(evt_rise),
        .fall(evt_fall)
    );

    // ==========================================
    // apb decode
    assign addr_ok = (paddr == `EMMT_OFS_CMP) || (paddr == `EMMT_OFS_CTRL) ||
                     (paddr == `EMMT_OFS_STAT);
    assign wr_en = psel & penable & pwrite;
    assign rd_en = psel & ~penable & ~pwrite;
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~addr_ok;
    assign prdata = rdata_r;
    assign ctrl_wr = wr_en & (paddr == `EMMT_OFS_CTRL);
    assign start_rise = ctrl_wr & pwdata[`EMMT_START_BIT] & ~run_start_bit;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            compare_value_register <= `EMMT_CMP_RST;
            run_start_bit <= 1'b0;
            count_source_select <= 3'b000;
            operating_mode_select <= 2'b00;
        end else begin
            if (wr_en && paddr == `EMMT_OFS_CMP) begin
                compare_value_register <= pwdata[7:0];
            end
            // stop power entry clears start
            // forced stop wins
            if (stop_mode_entry) begin
                run_start_bit <= 1'b0;
            end else if (ctrl_wr) begin
                run_start_bit <= pwdata[`EMMT_START_BIT];
            end
            if (ctrl_wr) begin
                count_source_select <= pwdata[`EMMT_SRC_MSB:`EMMT_SRC_LSB];
                operating_mode_select <= pwdata[`EMMT_MODE_MSB:`EMMT_MODE_LSB];
            end
        end
    end

    // read data registered during setup phase
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_r <= 32'h0000_0000;
        end else if (rd_en) begin
            case (paddr)
                `EMMT_OFS_CMP: rdata_r <= {24'h00_0000, compare_value_register};
                `EMMT_OFS_CTRL: rdata_r <= {26'h000_0000, run_start_bit,
                                             count_source_select, operating_mode_select};
                `EMMT_OFS_STAT: rdata_r <= {21'h00_0000, pwm_r, div_r, evt_wait_r, count_r};
                default: rdata_r <= 32'h0000_0000;
            endcase
        end
    end

    // ==========================================
    // count source selection
    // 111 picks event pin
    assign src_is_event = (count_source_select == `EMMT_SRC_EVENT);
    assign tick = src_is_event ? evt_rise : src_tick[count_source_select];
    assign count_inc = count_r + 8'h01;
    assign match = (count_r == compare_value_register);

    // ==========================================
    // counter and outputs
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_r <= 8'h00;
            pwm_cmp_r <= `EMMT_CMP_RST;
            div_r <= 1'b1;
            pwm_r <= 1'b1;
            irq_r <= 1'b0;
            evt_wait_r <= 1'b0;
            evt_hit_r <= 1'b0;
        end else begin
            irq_r <= 1'b0;
            if (!run_start_bit) begin
                count_r <= 8'h00;
                div_r <= 1'b1;
                pwm_r <= 1'b1;
                evt_wait_r <= 1'b0;
                evt_hit_r <= 1'b0;
                if (start_rise) begin
                    pwm_cmp_r <= compare_value_register;
                end
            end else begin
                case (operating_mode_select)
                    `EMMT_MODE_TIMER: begin
                        if (src_is_event) begin
                            if (tick) begin
                                count_r <= count_inc;
                                evt_wait_r <= 1'b0;
                                if (count_inc == compare_value_register) begin
                                    evt_hit_r <= 1'b1;
                                end
                            end
                            if (evt_fall && (evt_hit_r || match)) begin
                                irq_r <= 1'b1;
                                count_r <= 8'h00;
                                evt_hit_r <= 1'b0;
                                evt_wait_r <= 1'b1;
                            end
                        end else if (tick) begin
                            if (match) begin
                                irq_r <= 1'b1;
                                count_r <= 8'h00;
                            end else begin
                                count_r <= count_inc;
                            end
                        end
                    end
                    `EMMT_MODE_DIV: begin
                        if (tick) begin
                            if (match) begin
                                div_r <= ~div_r;
                                irq_r <= 1'b1;
                                count_r <= 8'h00;
                            end else begin
                                count_r <= count_inc;
                            end
                        end
                    end
                    `EMMT_MODE_PWM: begin
                        if (tick) begin
                            count_r <= count_inc;
                            if (count_r == 8'hff) begin
                                pwm_r <= 1'b1;
                                irq_r <= 1'b1;
                                pwm_cmp_r <= compare_value_register;
                            end else if (count_inc == pwm_cmp_r) begin
                                pwm_r <= 1'b0;
                            end
                        end
                    end
                    default: begin
                        count_r <= 8'h00;
                    end
                endcase
            end
        end
    end

    assign divider_output_pin = div_r;
    assign pwm_output_pin_n = pwm_r;
    assign timer_interrupt_request = irq_r;
endmodule

/* emmt_timer_bench.sv */
// self-checking bench for the multimode timer
`timescale 1ns/10ps
module emmt_timer_bench;
    localparam [11:0] cmp_a = 12'h019, ctl_a = 12'h015, sta_a = 12'h020;
    reg pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    reg stop_mode_entry = 1'b0;
    reg [2:0] tsel = 3'h0;
    reg [11:0] paddr = 12'h000;
    reg [31:0] pwdata = 32'h0000_0000, rd;
    reg [6:0] src_tick = 7'h00;
    wire [31:0] prdata;
    wire pready, pslverr, event_input_pin, divider_output_pin, pwm_output_pin_n;
    wire timer_interrupt_request;
    integer n_errors = 0, check_count = 0, n_irq = 0, t, u;
    always #5 pclk = ~pclk;
    always @(posedge pclk) begin
        src_tick <= (src_tick == 7'h00) ? 7'h01 << tsel : 7'h00;
        n_irq <= n_irq + (timer_interrupt_request === 1'b1);
    end
    emmt_timer dut_u (.*);
    emmt_event_src src_u (.*);
    task chk(input string s, input [31:0] g, input [31:0] e);
        check_count++;
        if (g !== e) begin
            n_errors++;
            $display("[ERR] %s exp %h got %h", s, e, g);
        end
    endtask
    task apb(input w, input [11:0] a, input [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task rdc(input string s, input [11:0] a, input [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        chk(s, rd, e);
    endtask
    task go(input [31:0] c, input [31:0] m);
        tsel <= m[4:2];
        apb(1'b1, cmp_a, c);
        apb(1'b1, ctl_a, m);
        apb(1'b1, ctl_a, m | 32'h0000_0020);
    endtask
    // width of a low level on a pin
    task lw(input d, output integer c);
        c = 0;
        while ((d ? divider_output_pin : pwm_output_pin_n) !== 1'b0) @(negedge pclk);
        while ((d ? divider_output_pin : pwm_output_pin_n) === 1'b0) begin
            @(negedge pclk);
            c++;
        end
    endtask
    task ig(output integer c);
        while (timer_interrupt_request !== 1'b1) @(negedge pclk);
        @(negedge pclk);
        c = 1;
        while (timer_interrupt_request !== 1'b1) begin
            @(negedge pclk);
            c++;
        end
    endtask
    task t_reset;
        rdc("cmp", cmp_a, 32'h0000_00ff);
        rdc("ctl", ctl_a, 32'h0000_0000);
        rdc("unmapped", 12'h030, 32'h0000_0000);
    endtask
    task t_timer;
        go(32'h0000_0003, 32'h0000_0004);
        rdc("ctl", ctl_a, 32'h0000_0024);
        ig(t);
        chk("timer gap", t, 32'h0000_0008);
        apb(1'b1, ctl_a, 32'h0000_0004);
        rdc("stopped", sta_a, 32'h0000_0600);
    endtask
    task t_div;
        go(32'h0000_0002, 32'h0000_0006);
        lw(1'b1, t);
        chk("half period", t, 32'h0000_0006);
        apb(1'b1, ctl_a, 32'h0000_0006);
        rdc("div stop", sta_a, 32'h0000_0600);
    endtask
    // pwm run in normal power, then stop power entry clears start
    task t_pwm;
        go(32'h0000_0040, 32'h0000_000f);
        lw(1'b0, t);
        chk("first duty", t, 32'h0000_0180);
        apb(1'b1, cmp_a, 32'h0000_0080);
        lw(1'b0, t);
        chk("held duty", t, 32'h0000_0180);
        lw(1'b0, t);
        chk("new duty", t, 32'h0000_0100);
        ig(t);
        chk("period", t, 32'h0000_0200);
        @(posedge pclk);
        stop_mode_entry <= 1'b1;
        @(posedge pclk);
        stop_mode_entry <= 1'b0;
        rdc("stop entry", ctl_a, 32'h0000_000f);
        rdc("pwm stop", sta_a, 32'h0000_0600);
    endtask
    task t_evt;
        go(32'h0000_0003, 32'h0000_001c);
        u = n_irq;
        src_u.pulses(3);
        repeat (5) @(posedge pclk);
        chk("event irq", n_irq - u, 32'h0000_0001);
        rdc("cleared", sta_a, 32'h0000_0700);
        src_u.pulses(1);
        rdc("recount", sta_a, 32'h0000_0601);
    endtask
    task print_verdict;
        if (n_errors == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        t_reset;
        t_timer;
        t_div;
        t_pwm;
        t_evt;
        print_verdict;
    end
    initial begin
        #200000;
        n_errors++;
        print_verdict;
    end
endmodule

/* emmt_timer_properties.sv */
// assertion checker for the multimode timer
`timescale 1ns/10ps
module emmt_timer_checker (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // apb
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    // pins
    input wire stop_mode_entry,
    input wire divider_output_pin,
    input wire pwm_output_pin_n,
    input wire timer_interrupt_request
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_acc;
        psel && penable;
    endsequence
    sequence s_bad;
        s_acc ##0 (!pwrite && !(paddr inside {12'h015, 12'h019, 12'h020}));
    endsequence
    property p_pulse; timer_interrupt_request |=> !timer_interrupt_request; endproperty
    a_pulse: assert property (p_pulse) else $error("irq wide");
    property p_stop;
        stop_mode_entry |-> ##[1:3] (divider_output_pin && pwm_output_pin_n);
    endproperty
    a_stop: assert property (p_stop) else $error("pin low after stop");
    property p_div; $fell(divider_output_pin) |-> ##[0:1] timer_interrupt_request; endproperty
    a_div: assert property (p_div) else $error("toggle without irq");
    property p_pwm; $fell(pwm_output_pin_n) |-> !timer_interrupt_request; endproperty
    a_pwm: assert property (p_pwm) else $error("irq at match");
    property p_one; divider_output_pin || pwm_output_pin_n; endproperty
    a_one: assert property (p_one) else $error("both pins low");
    property p_err; pslverr |-> psel && penable; endproperty
    a_err: assert property (p_err) else $error("stray error");
    property p_bad; s_bad |-> pslverr && prdata == 32'h0000_0000; endproperty
    a_bad: assert property (p_bad) else $error("unmapped accepted");
    property p_rdy; s_acc |-> pready; endproperty
    a_rdy: assert property (p_rdy) else $error("no ready");
endmodule
bind emmt_timer emmt_timer_checker chk_u (.*);
